// file: hdl/psf_pkg.sv
// Constants, codes and carrier types of the program security fuse controller
package psf_pkg;

  // ********************************************************************
  // Register addresses
  // ********************************************************************
  localparam logic [15:0] PSF_FLASH_CONTROL_ADDR = 16'h00B2;
  localparam logic [15:0] PSF_BURN_PULSE_ADDR = 16'hFFD1;
  localparam logic [15:0] PSF_FUSE_SELECT_ADDR = 16'hFFD2;
  localparam logic [15:0] PSF_PROTECT_FUSE_ADDR = 16'hFFD7;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int PSF_FC_WRITE_ENABLE_BIT = 0;
  localparam int PSF_FC_MASS_ERASE_EN_BIT = 1;
  localparam int PSF_FC_LOCK_BIT = 6;
  localparam int PSF_PF_LEVEL1_BIT = 0;
  localparam int PSF_PF_LEVEL0_BIT = 1;
  localparam int PSF_PF_PERMIT_BIT = 5;
  localparam int PSF_PF_ARM_BIT = 7;

  // ********************************************************************
  // Codes and reset values
  // ********************************************************************
  localparam logic [7:0] PSF_SETUP_CODE = 8'h54;
  localparam logic [7:0] PSF_SELECT_LEVEL0_CODE = 8'h81;
  localparam logic [7:0] PSF_SELECT_LEVEL1_CODE = 8'h82;
  localparam logic [7:0] PSF_BURN_CODE = 8'hA6;
  localparam logic [7:0] PSF_BYTE_RESET = 8'h00;
  localparam logic [6:0] PSF_PAGE_ZERO = 7'h00;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [2:0] {
    PSF_OP_READ_FLASH,
    PSF_OP_READ_RAM,
    PSF_OP_WRITE_FLASH,
    PSF_OP_PAGE_ERASE,
    PSF_OP_MASS_ERASE,
    PSF_OP_CORE_CONTROL
  } psf_dbg_op_type;

  typedef struct packed {
    logic req;
    psf_dbg_op_type op;
    logic [6:0] page;
  } psf_dbg_req_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } psf_sfr_bus_type;

  typedef struct packed {
    logic flash_wr;
    logic page_erase;
    logic [6:0] page;
  } psf_cpu_flash_type;

  typedef struct packed {
    logic grant;
    logic deny;
  } psf_answer_type;

endpackage

// file: hdl/psf_program_security_fuse_ctrl.sv
// Program security lock, fuse burn sequencer and access gate for flash and data RAM
module psf_program_security_fuse_ctrl (
  input wire logic ref_clk,
  input wire logic rst,
  input wire psf_pkg::psf_sfr_bus_type sfr_bus,
  input wire logic cpu_int_enabled,
  input wire psf_pkg::psf_cpu_flash_type cpu_flash,
  input wire psf_pkg::psf_dbg_req_type dbg_req,
  input wire logic permit_pin,
  input wire logic level0_fuse_sense,
  input wire logic level1_fuse_sense,
  output logic [7:0] sfr_rdata,
  output logic sfr_ack,
  output psf_pkg::psf_answer_type cpu_answer,
  output psf_pkg::psf_answer_type dbg_answer,
  output logic dbg_port_enable,
  output logic dbg_data_enable,
  output logic flash_write_enable,
  output logic mass_erase_enable,
  output logic flash_mass_erase,
  output logic ram_clear,
  output logic lock_bit_active,
  output logic burn_level0,
  output logic burn_level1
);

  // ********************************************************************
  // Fuse state and lock
  // ********************************************************************
  typedef enum logic [2:0] {
    PSF_IDLE,
    PSF_SETUP,
    PSF_SEL_L0,
    PSF_SEL_L1,
    PSF_BURN_L0,
    PSF_BURN_L1
  } psf_burn_state_type;

  logic level0_fuse;
  logic level1_fuse;
  logic lock_bit;
  logic fuse_program_arm;
  logic next_level0_fuse;
  logic next_level1_fuse;
  logic next_lock_bit;
  logic next_fuse_program_arm;

  logic wr_flash_control;
  logic wr_burn_pulse;
  logic wr_fuse_select;
  logic wr_protect_fuse;
  logic lock_bit_now;
  logic level1_now;

  assign wr_flash_control = sfr_bus.wr && (sfr_bus.addr == psf_pkg::PSF_FLASH_CONTROL_ADDR);
  assign wr_burn_pulse = sfr_bus.wr && (sfr_bus.addr == psf_pkg::PSF_BURN_PULSE_ADDR);
  assign wr_fuse_select = sfr_bus.wr && (sfr_bus.addr == psf_pkg::PSF_FUSE_SELECT_ADDR);
  assign wr_protect_fuse = sfr_bus.wr && (sfr_bus.addr == psf_pkg::PSF_PROTECT_FUSE_ADDR);

  // Lock has no force until the level0 fuse is blown
  assign lock_bit_now = lock_bit && level0_fuse;
  // Sense input bypasses the register so the port closes in the blowing cycle
  assign level1_now = level1_fuse || level1_fuse_sense;

  always_comb begin
    // Fuse bits only ever accumulate out of reset; reset reloads them from the sense inputs
    next_level0_fuse = level0_fuse || level0_fuse_sense;
    next_level1_fuse = level1_fuse || level1_fuse_sense;
    // Set-only: a zero written here leaves the bit alone
    next_lock_bit = lock_bit || (wr_flash_control && sfr_bus.wdata[psf_pkg::PSF_FC_LOCK_BIT]);
    next_fuse_program_arm = fuse_program_arm;
    if (wr_protect_fuse) begin
      next_fuse_program_arm = sfr_bus.wdata[psf_pkg::PSF_PF_ARM_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // Fuses are sampled while reset is held, before boot starts
      level0_fuse <= level0_fuse_sense;
      level1_fuse <= level1_fuse_sense;
      lock_bit <= 1'b0;
      fuse_program_arm <= 1'b0;
    end else begin
      level0_fuse <= next_level0_fuse;
      level1_fuse <= next_level1_fuse;
      lock_bit <= next_lock_bit;
      fuse_program_arm <= next_fuse_program_arm;
    end
  end

  // ********************************************************************
  // Fuse burn sequencer
  // ********************************************************************
  psf_burn_state_type burn_state;
  psf_burn_state_type next_burn_state;
  logic next_burn_level0;
  logic next_burn_level1;

  always_comb begin
    next_burn_state = burn_state;
    if (wr_fuse_select) begin
      case (burn_state)
        PSF_SETUP: begin
          // One level per burn; any other code abandons the setup
          if (sfr_bus.wdata == psf_pkg::PSF_SELECT_LEVEL0_CODE) begin
            next_burn_state = PSF_SEL_L0;
          end else if (sfr_bus.wdata == psf_pkg::PSF_SELECT_LEVEL1_CODE) begin
            next_burn_state = PSF_SEL_L1;
          end else begin
            next_burn_state = PSF_IDLE;
          end
        end
        PSF_BURN_L0, PSF_BURN_L1: begin
          // Selection writes during a burn are ignored
          next_burn_state = burn_state;
        end
        default: begin
          if (sfr_bus.wdata == psf_pkg::PSF_SETUP_CODE) begin
            next_burn_state = PSF_SETUP;
          end else begin
            next_burn_state = PSF_IDLE;
          end
        end
      endcase
    end else if (wr_burn_pulse) begin
      case (burn_state)
        PSF_SEL_L0: begin
          if (sfr_bus.wdata == psf_pkg::PSF_BURN_CODE && fuse_program_arm) begin
            next_burn_state = PSF_BURN_L0;
          end else begin
            next_burn_state = PSF_IDLE;
          end
        end
        PSF_SEL_L1: begin
          if (sfr_bus.wdata == psf_pkg::PSF_BURN_CODE && fuse_program_arm) begin
            next_burn_state = PSF_BURN_L1;
          end else begin
            next_burn_state = PSF_IDLE;
          end
        end
        PSF_BURN_L0, PSF_BURN_L1: begin
          if (sfr_bus.wdata != psf_pkg::PSF_BURN_CODE) begin
            next_burn_state = PSF_IDLE;
          end
        end
        default: begin
          next_burn_state = PSF_IDLE;
        end
      endcase
    end else if (!fuse_program_arm &&
                 (burn_state == PSF_BURN_L0 || burn_state == PSF_BURN_L1)) begin
      // Dropping the arm bit cuts the burn current
      next_burn_state = PSF_IDLE;
    end
    next_burn_level0 = (next_burn_state == PSF_BURN_L0);
    // Permit pin gates the level1 current; level0 ignores it
    next_burn_level1 = (next_burn_state == PSF_BURN_L1) && permit_pin;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      burn_state <= PSF_IDLE;
      burn_level0 <= 1'b0;
      burn_level1 <= 1'b0;
    end else begin
      burn_state <= next_burn_state;
      burn_level0 <= next_burn_level0;
      burn_level1 <= next_burn_level1;
    end
  end

  // ********************************************************************
  // Flash control bits
  // ********************************************************************
  logic next_flash_write_enable;
  logic next_mass_erase_enable;
  logic cpu_wr_granted;
  logic mass_erase_granted;

  always_comb begin
    next_flash_write_enable = flash_write_enable;
    next_mass_erase_enable = mass_erase_enable;
    // Write enable clears itself after each flash byte
    if (cpu_wr_granted) begin
      next_flash_write_enable = 1'b0;
    end
    // Register writes leave write enable alone while interrupts are enabled
    if (wr_flash_control && !cpu_int_enabled) begin
      next_flash_write_enable = sfr_bus.wdata[psf_pkg::PSF_FC_WRITE_ENABLE_BIT];
    end
    if (mass_erase_granted) begin
      next_mass_erase_enable = 1'b0;
    end
    if (wr_flash_control) begin
      next_mass_erase_enable = sfr_bus.wdata[psf_pkg::PSF_FC_MASS_ERASE_EN_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flash_write_enable <= 1'b0;
      mass_erase_enable <= 1'b0;
    end else begin
      flash_write_enable <= next_flash_write_enable;
      mass_erase_enable <= next_mass_erase_enable;
    end
  end

  // ********************************************************************
  // Access gate for processor and debug port
  // ********************************************************************
  psf_pkg::psf_answer_type next_cpu_answer;
  psf_pkg::psf_answer_type next_dbg_answer;
  logic cpu_page_zero;
  logic dbg_page_zero;
  logic dbg_allowed;
  logic next_flash_mass_erase;
  logic next_ram_clear;

  assign cpu_page_zero = (cpu_flash.page == psf_pkg::PSF_PAGE_ZERO);
  assign dbg_page_zero = (dbg_req.page == psf_pkg::PSF_PAGE_ZERO);
  assign cpu_wr_granted = cpu_flash.flash_wr && !(lock_bit_now && cpu_page_zero);
  assign mass_erase_granted = dbg_req.req && dbg_allowed &&
                              (dbg_req.op == psf_pkg::PSF_OP_MASS_ERASE);

  always_comb begin
    dbg_allowed = 1'b1;
    if (level1_now) begin
      dbg_allowed = 1'b0;
    end else if (lock_bit_now) begin
      // Bulk erase is the only debug operation allowed in the locked state
      dbg_allowed = (dbg_req.op == psf_pkg::PSF_OP_MASS_ERASE);
    end else if ((dbg_req.op == psf_pkg::PSF_OP_WRITE_FLASH ||
                  dbg_req.op == psf_pkg::PSF_OP_PAGE_ERASE) && dbg_page_zero && lock_bit &&
                 level0_fuse) begin
      dbg_allowed = 1'b0;
    end
    next_dbg_answer.grant = dbg_req.req && dbg_allowed;
    next_dbg_answer.deny = dbg_req.req && !dbg_allowed;
    next_cpu_answer.grant = 1'b0;
    next_cpu_answer.deny = 1'b0;
    if (cpu_flash.flash_wr || cpu_flash.page_erase) begin
      if (lock_bit_now && cpu_page_zero) begin
        next_cpu_answer.deny = 1'b1;
      end else begin
        next_cpu_answer.grant = 1'b1;
      end
    end
    // Global erase wipes data RAM whether locked or not
    next_flash_mass_erase = mass_erase_granted;
    next_ram_clear = mass_erase_granted;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cpu_answer <= '0;
      dbg_answer <= '0;
      flash_mass_erase <= 1'b0;
      ram_clear <= 1'b0;
      dbg_port_enable <= 1'b0;
      dbg_data_enable <= 1'b0;
      lock_bit_active <= 1'b0;
    end else begin
      cpu_answer <= next_cpu_answer;
      dbg_answer <= next_dbg_answer;
      flash_mass_erase <= next_flash_mass_erase;
      ram_clear <= next_ram_clear;
      dbg_port_enable <= !level1_now;
      dbg_data_enable <= !level1_now && !lock_bit_now;
      lock_bit_active <= lock_bit_now;
    end
  end

  // ********************************************************************
  // Register read port
  // ********************************************************************
  logic [7:0] next_sfr_rdata;
  logic next_sfr_ack;

  always_comb begin
    next_sfr_rdata = psf_pkg::PSF_BYTE_RESET;
    next_sfr_ack = 1'b0;
    if (sfr_bus.rd || sfr_bus.wr) begin
      if (sfr_bus.addr == psf_pkg::PSF_FLASH_CONTROL_ADDR) begin
        next_sfr_ack = 1'b1;
        next_sfr_rdata[psf_pkg::PSF_FC_WRITE_ENABLE_BIT] = flash_write_enable;
        next_sfr_rdata[psf_pkg::PSF_FC_LOCK_BIT] = lock_bit;
      end else if (sfr_bus.addr == psf_pkg::PSF_PROTECT_FUSE_ADDR) begin
        next_sfr_ack = 1'b1;
        next_sfr_rdata[psf_pkg::PSF_PF_ARM_BIT] = fuse_program_arm;
        next_sfr_rdata[psf_pkg::PSF_PF_PERMIT_BIT] = permit_pin;
        next_sfr_rdata[psf_pkg::PSF_PF_LEVEL0_BIT] = level0_fuse;
        next_sfr_rdata[psf_pkg::PSF_PF_LEVEL1_BIT] = level1_fuse;
      end else if (sfr_bus.addr == psf_pkg::PSF_BURN_PULSE_ADDR ||
                   sfr_bus.addr == psf_pkg::PSF_FUSE_SELECT_ADDR) begin
        // Write-only registers read as zero
        next_sfr_ack = 1'b1;
      end
    end
    if (!sfr_bus.rd) begin
      next_sfr_rdata = psf_pkg::PSF_BYTE_RESET;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sfr_rdata <= psf_pkg::PSF_BYTE_RESET;
      sfr_ack <= 1'b0;
    end else begin
      sfr_rdata <= next_sfr_rdata;
      sfr_ack <= next_sfr_ack;
    end
  end

endmodule

// file: tb/psf_checker_assertions.sv
// Port-level checks for the security fuse controller
module psf_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire psf_pkg::psf_sfr_bus_type sfr_bus,
  input wire psf_pkg::psf_cpu_flash_type cpu_flash,
  input wire psf_pkg::psf_dbg_req_type dbg_req,
  input wire logic permit_pin,
  input wire logic level1_fuse_sense,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_ack,
  input wire psf_pkg::psf_answer_type cpu_answer,
  input wire psf_pkg::psf_answer_type dbg_answer,
  input wire logic dbg_port_enable,
  input wire logic dbg_data_enable,
  input wire logic ram_clear,
  input wire logic lock_bit_active,
  input wire logic burn_level0,
  input wire logic burn_level1
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ********************************************************************
  // Assertions
  // ********************************************************************
  AST_LOCK_HOLD: assert property (lock_bit_active |=> lock_bit_active)
    else $error("lock dropped without reset");
  AST_RESET_CLEAR: assert property ($fell(rst) |-> !lock_bit_active && !burn_level0)
    else $error("state not cleared by reset");
  AST_DBG_LOCKED: assert property (dbg_req.req && lock_bit_active &&
    dbg_req.op != psf_pkg::PSF_OP_MASS_ERASE |=> dbg_answer.deny && !dbg_answer.grant)
    else $error("locked debug port granted access");
  AST_DBG_ERASE: assert property (dbg_req.req && dbg_port_enable && !level1_fuse_sense &&
    dbg_req.op == psf_pkg::PSF_OP_MASS_ERASE |=> dbg_answer.grant && ram_clear)
    else $error("bulk erase did not clear data memory");
  AST_PAGE0: assert property ((cpu_flash.flash_wr || cpu_flash.page_erase) &&
    cpu_flash.page == psf_pkg::PSF_PAGE_ZERO && lock_bit_active |=> cpu_answer.deny)
    else $error("page zero change not refused");
  AST_DATA_LOCKED: assert property (lock_bit_active |-> !dbg_data_enable)
    else $error("data path open while locked");
  AST_LEVEL1_OFF: assert property (level1_fuse_sense |=> !dbg_port_enable &&
    !dbg_data_enable) else $error("debug port alive with level1 fuse");
  AST_PORT_STAYS_OFF: assert property (!dbg_port_enable && !$past(rst) |=>
    !dbg_port_enable) else $error("debug port came back");
  AST_PERMIT_READ: assert property (sfr_bus.rd &&
    sfr_bus.addr == psf_pkg::PSF_PROTECT_FUSE_ADDR |=> sfr_ack &&
    sfr_rdata[psf_pkg::PSF_PF_PERMIT_BIT] == $past(permit_pin))
    else $error("permit level misread");
  AST_BURN1_PERMIT: assert property (burn_level1 |-> $past(permit_pin))
    else $error("level1 burn without permit");
  AST_BURN_STOP: assert property (sfr_bus.wr && sfr_bus.addr == psf_pkg::PSF_BURN_PULSE_ADDR &&
    sfr_bus.wdata != psf_pkg::PSF_BURN_CODE |=> !burn_level0 && !burn_level1)
    else $error("burn not stopped");
  COV_ERASE: cover property (dbg_answer.grant && ram_clear);
  COV_BURN1: cover property (burn_level1);
  COV_DENY: cover property (cpu_answer.deny);
endmodule

// file: tb/psf_debug_host.sv
// Behavioural emulator debug host, one request at a time
module psf_debug_host (
  input wire logic ref_clk,
  input wire psf_pkg::psf_answer_type dbg_answer,
  output psf_pkg::psf_dbg_req_type dbg_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial dbg_req = '{req: 1'b0, op: psf_pkg::PSF_OP_READ_FLASH, page: 7'h7F};
  // Released qualifiers are inverted so stale values never look valid
  task automatic issue(input psf_pkg::psf_dbg_op_type op, input logic [6:0] pg,
                       output psf_pkg::psf_answer_type ans);
    dbg_req <= '{req: 1'b1, op: op, page: pg};
    @(posedge ref_clk);
    dbg_req <= '{req: 1'b0, op: psf_pkg::psf_dbg_op_type'(~op), page: ~pg};
    @(posedge ref_clk);
    ans = dbg_answer;
  endtask
endmodule

// file: tb/psf_program_security_fuse_ctrl_test.sv
// Self-checking bench for the security fuse controller
module psf_program_security_fuse_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  psf_pkg::psf_sfr_bus_type sfr_bus = '0;
  psf_pkg::psf_cpu_flash_type cpu_flash = '0;
  psf_pkg::psf_dbg_req_type dbg_req;
  psf_pkg::psf_answer_type cpu_answer, dbg_answer, ans;
  psf_pkg::psf_dbg_op_type op;
  logic cpu_int_enabled = 1'b0;
  logic permit_pin = 1'b0;
  logic level0_fuse_sense = 1'b0;
  logic level1_fuse_sense = 1'b0;
  logic [7:0] sfr_rdata, rd;
  logic sfr_ack, dbg_port_enable, ram_clear, lock_bit_active, burn_level0, burn_level1;
  logic flash_write_enable, mass_erase_enable, flash_mass_erase;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  integer seed = 11503;

  psf_program_security_fuse_ctrl psf_program_security_fuse_ctrl_inst (.ref_clk, .rst, .sfr_bus,
    .cpu_int_enabled, .cpu_flash, .dbg_req, .permit_pin, .level0_fuse_sense,
    .level1_fuse_sense, .sfr_rdata, .sfr_ack, .cpu_answer, .dbg_answer, .dbg_port_enable,
    .dbg_data_enable(), .flash_write_enable, .mass_erase_enable, .flash_mass_erase,
    .ram_clear, .lock_bit_active, .burn_level0, .burn_level1);
  psf_debug_host psf_debug_host_inst (.ref_clk, .dbg_answer, .dbg_req);

  always #4 ref_clk = ~ref_clk;
  // Run needs about 130 cycles; the ceiling leaves wide margin
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      $display("unexpected at %0t: run timed out", $time);
      complete_run();
    end
  end

  // ********************************************************************
  // Tasks and expectations
  // ********************************************************************
  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
      errors++;
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    sfr_bus <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge ref_clk);
    sfr_bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    @(posedge ref_clk);
    rd = sfr_ack ? sfr_rdata : 8'hEE;
  endtask
  task automatic burn(input logic [7:0] sel);
    bus(1'b1, psf_pkg::PSF_FUSE_SELECT_ADDR, psf_pkg::PSF_SETUP_CODE);
    bus(1'b1, psf_pkg::PSF_FUSE_SELECT_ADDR, sel);
    bus(1'b1, psf_pkg::PSF_BURN_PULSE_ADDR, psf_pkg::PSF_BURN_CODE);
  endtask
  task automatic cpu(input logic pe, input logic [6:0] pg);
    cpu_flash <= '{flash_wr: !pe, page_erase: pe, page: pg};
    @(posedge ref_clk);
    cpu_flash <= '{flash_wr: 1'b0, page_erase: 1'b0, page: ~pg};
    @(posedge ref_clk);
    ans = cpu_answer;
  endtask
  task automatic reset_dut(input int n);
    rst <= 1'b1;
    repeat (n) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic dbg(input logic lock, input logic l1, input logic [6:0] pg);
    psf_debug_host_inst.issue(op, pg, ans);
    chk({ans.grant, ram_clear, flash_mass_erase}, exp_dbg(lock, l1));
  endtask
  function automatic logic [7:0] exp_prot(logic arm, logic l0, logic pin);
    return {arm, 1'b0, pin, 3'b000, l0, 1'b0};
  endfunction
  function automatic logic [7:0] exp_dbg(logic lock, logic l1);
    logic erase;
    erase = op == psf_pkg::PSF_OP_MASS_ERASE;
    return {5'h00, !l1 && (!lock || erase), !l1 && erase, !l1 && erase};
  endfunction

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    reset_dut(10);
    bus(1'b0, psf_pkg::PSF_FLASH_CONTROL_ADDR, 8'h00);
    chk(rd, 8'h00);
    bus(1'b0, 16'h1234, 8'h00);
    chk(rd, 8'hEE);
    bus(1'b1, psf_pkg::PSF_FLASH_CONTROL_ADDR, 8'h40);
    chk(8'(lock_bit_active), 8'h00);
    for (int i = 0; i < 8; i++) begin
      op = psf_pkg::psf_dbg_op_type'(3'($unsigned($random(seed)) % 6));
      dbg(1'b0, 1'b0, 7'($random(seed)));
    end
    bus(1'b1, psf_pkg::PSF_FLASH_CONTROL_ADDR, 8'h00);
    bus(1'b0, psf_pkg::PSF_FLASH_CONTROL_ADDR, 8'h00);
    chk(rd, 8'h40);
    // Write enable frozen while interrupts are on; zero to lock ignored
    cpu_int_enabled <= 1'b1;
    bus(1'b1, psf_pkg::PSF_FLASH_CONTROL_ADDR, 8'h03);
    chk({6'h00, mass_erase_enable, flash_write_enable}, 8'h02);
    cpu_int_enabled <= 1'b0;
    bus(1'b1, psf_pkg::PSF_FLASH_CONTROL_ADDR, 8'h01);
    chk({6'h00, mass_erase_enable, flash_write_enable}, 8'h01);
    // Lock without level0 fuse leaves page zero writable
    cpu(1'b0, psf_pkg::PSF_PAGE_ZERO);
    chk({6'h00, ans.grant, flash_write_enable}, 8'h02);
    for (int i = 0; i < 6; i++) begin
      permit_pin <= 1'($random(seed));
      bus(1'b0, psf_pkg::PSF_PROTECT_FUSE_ADDR, 8'h00);
      chk(rd, exp_prot(1'b0, 1'b0, permit_pin));
    end
    permit_pin <= 1'b0;
    burn(psf_pkg::PSF_SELECT_LEVEL0_CODE);
    chk(8'(burn_level0), 8'h00);
    bus(1'b1, psf_pkg::PSF_PROTECT_FUSE_ADDR, 8'h83);
    bus(1'b0, psf_pkg::PSF_PROTECT_FUSE_ADDR, 8'h00);
    chk(rd, exp_prot(1'b1, 1'b0, 1'b0));
    burn(psf_pkg::PSF_SELECT_LEVEL0_CODE);
    chk({burn_level1, burn_level0}, 8'h01);
    bus(1'b1, psf_pkg::PSF_BURN_PULSE_ADDR, 8'h5A);
    chk(8'(burn_level0), 8'h00);
    burn(psf_pkg::PSF_SELECT_LEVEL1_CODE);
    chk(8'(burn_level1), 8'h00);
    bus(1'b1, psf_pkg::PSF_BURN_PULSE_ADDR, 8'h00);
    permit_pin <= 1'b1;
    burn(psf_pkg::PSF_SELECT_LEVEL1_CODE);
    chk({burn_level1, burn_level0}, 8'h02);
    bus(1'b1, psf_pkg::PSF_BURN_PULSE_ADDR, 8'h00);
    chk(8'(burn_level1), 8'h00);
    level0_fuse_sense <= 1'b1;
    // Fuse register, then the registered lock_bit_active flag: two edges before it shows
    repeat (3) @(posedge ref_clk);
    chk(8'(lock_bit_active), 8'h01);
    bus(1'b1, psf_pkg::PSF_FLASH_CONTROL_ADDR, 8'h42);
    chk(8'(mass_erase_enable), 8'h01);
    for (int i = 0; i < 6; i++) begin
      op = psf_pkg::psf_dbg_op_type'(i);
      dbg(1'b1, 1'b0, psf_pkg::PSF_PAGE_ZERO);
    end
    chk(8'(mass_erase_enable), 8'h00);
    cpu(1'b1, psf_pkg::PSF_PAGE_ZERO);
    chk(8'(ans.deny), 8'h01);
    cpu(1'b0, psf_pkg::PSF_PAGE_ZERO);
    chk(8'(ans.deny), 8'h01);
    cpu(1'b1, 7'h05);
    chk(8'(ans.grant), 8'h01);
    chk(8'(lock_bit_active), 8'h01);
    reset_dut(2);
    chk(8'(lock_bit_active), 8'h00);
    op = psf_pkg::PSF_OP_READ_RAM;
    dbg(1'b0, 1'b0, 7'h01);
    level1_fuse_sense <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk(8'(dbg_port_enable), 8'h00);
    op = psf_pkg::PSF_OP_MASS_ERASE;
    dbg(1'b0, 1'b1, 7'h00);
    level1_fuse_sense <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(8'(dbg_port_enable), 8'h00);
    level1_fuse_sense <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    level1_fuse_sense <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(8'(dbg_port_enable), 8'h00);
    complete_run();
  end
endmodule

bind psf_program_security_fuse_ctrl psf_checker psf_checker_inst (.ref_clk, .rst, .sfr_bus,
  .cpu_flash, .dbg_req, .permit_pin, .level1_fuse_sense, .sfr_rdata, .sfr_ack, .cpu_answer,
  .dbg_answer, .dbg_port_enable, .dbg_data_enable, .ram_clear, .lock_bit_active, .burn_level0,
  .burn_level1);
